// ==== hw/mmd_defines.svh ====
// Constants for the memory map decoder: address fields, region bounds and flash geometry.
// Assumes inclusion by bare name from the package and the decoder module.
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH

// ----------------------------------------
// Vector table
// ----------------------------------------
`define MMD_VECBASE_SHIFT  7
`define MMD_VECBASE_RESET  14'h0200
`define MMD_VEC_FIRST      7'h4a
`define MMD_VEC_COUNT      7
`define MMD_JUMP_BITS      19
`define MMD_PRIO_MAX       2'h2

// ----------------------------------------
// Data map, word addresses
// ----------------------------------------
`define MMD_RAM_LAST       24'h001fff
`define MMD_DFLASH_FIRST   24'h002000
`define MMD_DFLASH_LAST    24'h002fff
`define MMD_PERIPH_FIRST   24'h00f000
`define MMD_PERIPH_LAST    24'h00ffff
`define MMD_DEBUG_FIRST    24'hffff00
`define MMD_RAM_ROW_LSB    1

// ----------------------------------------
// Flash configuration words and geometry
// ----------------------------------------
`define MMD_CFG_WORDS      9
`define MMD_CFG_FIRST      21'h01fff7
`define MMD_PF_SECT_LSB    13
`define MMD_PF_PAGE_LSB    9
`define MMD_DF_SECT_LSB    8
`define MMD_BF_SECT_LSB    11
`define MMD_BF_PAGE_LSB    8

`endif

// ==== hw/mmd_pkg.sv ====
// Types shared by the memory map decoder and whoever connects to it.
// Assumes the defines header sits next to it.
package mmd_pkg;
	`include "mmd_defines.svh"

	// Target of one data-space access.
	typedef enum logic [2:0] {
		MMD_RGN_RAM,
		MMD_RGN_DFLASH,
		MMD_RGN_PERIPH,
		MMD_RGN_DEBUG,
		MMD_RGN_EXTERNAL
	} mmd_region_t;

	// Flash block whose geometry is asked for.
	typedef enum logic [1:0] {
		MMD_BLK_PROGRAM,
		MMD_BLK_DATA,
		MMD_BLK_BOOT
	} mmd_block_t;

	// Registered answer of the data-space decode.
	typedef struct packed {
		logic        valid;
		mmd_region_t region;
		logic [10:0] ram_row;
		logic        ram_upper;
		logic        long_ok;
	} mmd_data_dec_t;

	// Registered answer of a vector fetch.
	typedef struct packed {
		logic        valid;
		logic [20:0] fetch_addr;
		logic        reset_slot;
		logic [20:0] jump_target;
	} mmd_vec_ans_t;

	// Registered flash geometry answer.
	typedef struct packed {
		logic        valid;
		logic [3:0]  sector;
		logic [3:0]  page;
		logic        data_bank;
	} mmd_geom_t;
endpackage : mmd_pkg

// ==== hw/mmd_memory_map_decoder.sv ====
// Address-map logic: vector fetch addresses, data-space decode, flash geometry and
// the load of the flash configuration words at chip initialization.
// Assumes every input comes from core logic on core_clk, and that the flash read port
// answers a read with rd_valid some cycles later, one read outstanding at a time.

`include "mmd_defines.svh"

module mmd_memory_map_decoder #(
	parameter int VEC_W = 7
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// Vector fetch request.
	input  wire logic                 vec_req,
	input  wire logic [13:0]          vector_base,
	input  wire logic [VEC_W-1:0]     vec_num,
	input  wire logic [15:0]          vec_word_lo,
	input  wire logic [15:0]          vec_word_hi,
	output mmd_pkg::mmd_vec_ans_t     vec_ans,
	// Converter and PWM events for vectors 74 to 80.
	input  wire logic [6:0]           evt_pending,
	input  wire logic [13:0]          evt_prio,
	output logic                      evt_req,
	output logic [VEC_W-1:0]          evt_vec,
	output logic [1:0]                evt_level,
	// Data-space decode.
	input  wire logic                 data_req,
	input  wire logic [23:0]          data_addr,
	input  wire logic                 data_long,
	input  wire logic                 external_data_select,
	output mmd_pkg::mmd_data_dec_t    data_dec,
	// Flash geometry query.
	input  wire logic                 geom_req,
	input  wire mmd_pkg::mmd_block_t  geom_block,
	input  wire logic [16:0]          geom_off,
	output mmd_pkg::mmd_geom_t        geom,
	// Flash configuration load.
	output logic                      fl_rd_req,
	output logic [20:0]               fl_rd_addr,
	input  wire logic                 fl_rd_valid,
	input  wire logic [15:0]          fl_rd_data,
	output logic [`MMD_CFG_WORDS*16-1:0] flash_cfg,
	output logic                      cfg_done
);
	import mmd_pkg::*;

	// ----------------------------------------
	// Vector fetch
	// ----------------------------------------

	// The base sits above the table offset; each entry spans two words.
	wire logic [20:0] vec_base_addr = {vector_base, {`MMD_VECBASE_SHIFT{1'b0}}};
	wire logic [20:0] vec_offset    = {{(20-VEC_W){1'b0}}, vec_num, 1'b0};
	wire logic [20:0] vec_fetch     = vec_base_addr + vec_offset;
	// Slots 0 and 1 hold the chip reset addresses when the base is the reset region.
	wire logic        vec_is_reset  = (vector_base == `MMD_VECBASE_RESET)
	                                  && (vec_num[VEC_W-1:1] == '0);
	// Only 19 bits of the two entry words reach the program counter.
	wire logic [20:0] vec_jump      = {2'b00, vec_word_hi[`MMD_JUMP_BITS-17:0], vec_word_lo};

	mmd_vec_ans_t vec_ans_d;
	mmd_vec_ans_t vec_ans_q;

	assign vec_ans_d.valid       = vec_req;
	assign vec_ans_d.fetch_addr  = vec_fetch;
	assign vec_ans_d.reset_slot  = vec_req && vec_is_reset;
	// A reset slot never yields a jump target, so a stray fetch cannot vector there.
	assign vec_ans_d.jump_target = vec_is_reset ? 21'h000000 : vec_jump;

	// ----------------------------------------
	// Converter and PWM event arbitration
	// ----------------------------------------

	logic [VEC_W-1:0] arb_vec;
	logic [1:0]       arb_lvl;
	logic             arb_hit;

	// Highest level wins; ties go to the lower vector number. Level 3 is clamped to 2
	// because the table only defines levels 0 to 2.
	always_comb begin
		logic [1:0] lvl;
		lvl     = 2'h0;
		arb_vec = '0;
		arb_lvl = 2'h0;
		arb_hit = 1'b0;
		for (int i = 0; i < `MMD_VEC_COUNT; i++) begin
			lvl = (evt_prio[2*i +: 2] > `MMD_PRIO_MAX) ? `MMD_PRIO_MAX : evt_prio[2*i +: 2];
			if (evt_pending[i] && (!arb_hit || lvl > arb_lvl)) begin
				arb_hit = 1'b1;
				arb_lvl = lvl;
				arb_vec = VEC_W'(`MMD_VEC_FIRST) + VEC_W'(i);
			end
		end
	end

	// ----------------------------------------
	// Data-space decode
	// ----------------------------------------

	// Addresses are word addresses; no byte bit is dropped anywhere below.
	wire logic in_low    = data_addr <= `MMD_RAM_LAST;
	wire logic in_dflash = (data_addr >= `MMD_DFLASH_FIRST) && (data_addr <= `MMD_DFLASH_LAST);
	wire logic in_periph = (data_addr >= `MMD_PERIPH_FIRST) && (data_addr <= `MMD_PERIPH_LAST);
	wire logic in_debug  = data_addr >= `MMD_DEBUG_FIRST;

	mmd_region_t dec_region;
	// The two fixed windows take precedence over the select bit; the rest is external.
	assign dec_region = in_debug  ? MMD_RGN_DEBUG :
	                    in_periph ? MMD_RGN_PERIPH :
	                    (in_low && !external_data_select)    ? MMD_RGN_RAM :
	                    (in_dflash && !external_data_select) ? MMD_RGN_DFLASH :
	                    MMD_RGN_EXTERNAL;

	mmd_data_dec_t data_dec_d;
	mmd_data_dec_t data_dec_q;

	assign data_dec_d.valid     = data_req;
	assign data_dec_d.region    = dec_region;
	// Two words share a 32-bit row, so an even-aligned long word is one row.
	assign data_dec_d.ram_row   = data_addr[`MMD_RAM_ROW_LSB +: 11];
	assign data_dec_d.ram_upper = data_addr[0];
	assign data_dec_d.long_ok   = data_long && !data_addr[0] && (dec_region == MMD_RGN_RAM);

	// ----------------------------------------
	// Flash geometry
	// ----------------------------------------

	mmd_geom_t geom_d;
	logic [3:0] g_sect;
	logic [3:0] g_page;

	// Page index is counted within its sector; in data flash the two coincide.
	always_comb begin
		case (geom_block)
			MMD_BLK_PROGRAM: begin
				g_sect = geom_off[`MMD_PF_SECT_LSB +: 4];
				g_page = geom_off[`MMD_PF_PAGE_LSB +: 4];
			end
			MMD_BLK_DATA: begin
				g_sect = geom_off[`MMD_DF_SECT_LSB +: 4];
				g_page = 4'h0;
			end
			MMD_BLK_BOOT: begin
				g_sect = {2'b00, geom_off[`MMD_BF_SECT_LSB +: 2]};
				g_page = {1'b0, geom_off[`MMD_BF_PAGE_LSB +: 3]};
			end
			default: begin
				g_sect = 4'h0;
				g_page = 4'h0;
			end
		endcase
	end

	assign geom_d.valid     = geom_req;
	assign geom_d.sector    = g_sect;
	assign geom_d.page      = g_page;
	// Program and boot flash answer to the same register bank.
	assign geom_d.data_bank = (geom_block == MMD_BLK_DATA);

	// ----------------------------------------
	// Flash configuration load
	// ----------------------------------------

	// The start state exists so that the first read is raised on the first edge after
	// reset; the request is registered from the next state, so a load that began in the
	// issue state would never present the first address to the flash.
	typedef enum logic [1:0] {
		CFG_START,
		CFG_ISSUE,
		CFG_WAIT,
		CFG_DONE
	} mmd_cfg_state_t;

	mmd_cfg_state_t cfg_state_q;
	mmd_cfg_state_t cfg_state_d;
	logic [3:0]     cfg_idx_q;
	logic [3:0]     cfg_idx_d;
	logic [15:0]    cfg_mem_q [`MMD_CFG_WORDS];

	wire logic cfg_last  = cfg_idx_q == 4'(`MMD_CFG_WORDS - 1);
	wire logic cfg_store = (cfg_state_q == CFG_WAIT) && fl_rd_valid;

	// One word at a time, so a slow flash can take as long as it needs.
	always_comb begin
		cfg_state_d = cfg_state_q;
		cfg_idx_d   = cfg_idx_q;
		case (cfg_state_q)
			CFG_START: cfg_state_d = CFG_ISSUE;
			CFG_ISSUE: cfg_state_d = CFG_WAIT;
			CFG_WAIT: begin
				if (fl_rd_valid) begin
					cfg_state_d = cfg_last ? CFG_DONE : CFG_ISSUE;
					cfg_idx_d   = cfg_last ? cfg_idx_q : cfg_idx_q + 4'h1;
				end
			end
			CFG_DONE: cfg_state_d = CFG_DONE;
			default:  cfg_state_d = CFG_ISSUE;
		endcase
	end

	// Load sequencer and captured configuration words.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_state_q <= CFG_START;
			cfg_idx_q   <= 4'h0;
			fl_rd_req   <= 1'b0;
			fl_rd_addr  <= 21'h000000;
			cfg_done    <= 1'b0;
			for (int i = 0; i < `MMD_CFG_WORDS; i++) begin
				cfg_mem_q[i] <= 16'h0000;
			end
		end else begin
			cfg_state_q <= cfg_state_d;
			cfg_idx_q   <= cfg_idx_d;
			fl_rd_req   <= (cfg_state_d == CFG_ISSUE);
			fl_rd_addr  <= `MMD_CFG_FIRST + {17'h00000, cfg_idx_d};
			cfg_done    <= (cfg_state_d == CFG_DONE);
			if (cfg_store) begin
				cfg_mem_q[cfg_idx_q] <= fl_rd_data;
			end
		end
	end

	// Word 0 of the block sits in the low bits of the bus.
	always_comb begin
		for (int i = 0; i < `MMD_CFG_WORDS; i++) begin
			flash_cfg[16*i +: 16] = cfg_mem_q[i];
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------

	// Every answer appears one cycle after its request.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			vec_ans_q  <= '0;
			data_dec_q <= '0;
			geom       <= '0;
			evt_req    <= 1'b0;
			evt_vec    <= '0;
			evt_level  <= 2'h0;
		end else begin
			vec_ans_q  <= vec_ans_d;
			data_dec_q <= data_dec_d;
			geom       <= geom_d;
			evt_req    <= arb_hit;
			evt_vec    <= arb_vec;
			evt_level  <= arb_lvl;
		end
	end

	assign vec_ans  = vec_ans_q;
	assign data_dec = data_dec_q;
endmodule : mmd_memory_map_decoder

// ==== testbench/mmd_checker.sv ====
// Concurrent checks on the ports of the memory map decoder.
// Assumes it is bound onto mmd_memory_map_decoder and sees only its ports.
module mmd_checker
	import mmd_pkg::*;
#(
	parameter int VEC_W = 7
) (
	input wire logic                core_clk,
	input wire logic                rst,
	input wire logic                vec_req,
	input wire logic [13:0]         vector_base,
	input wire logic [VEC_W-1:0]    vec_num,
	input wire mmd_vec_ans_t        vec_ans,
	input wire logic [6:0]          evt_pending,
	input wire logic                evt_req,
	input wire logic [VEC_W-1:0]    evt_vec,
	input wire logic [1:0]          evt_level,
	input wire logic                data_req,
	input wire logic [23:0]         data_addr,
	input wire logic                external_data_select,
	input wire mmd_data_dec_t       data_dec,
	input wire logic                fl_rd_req,
	input wire logic [20:0]         fl_rd_addr,
	input wire logic                fl_rd_valid,
	input wire logic                cfg_done
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Helpers and properties
	// ----------------------------------------
	logic [10:0] row_w;
	logic        sel_w;

	// Word address halved gives the RAM row; the select bit is named for brevity.
	assign row_w = data_addr[11:1];
	assign sel_w = external_data_select;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// A returned configuration word, either any one before the last or the last one.
	sequence s_more;
		fl_rd_valid && !cfg_done && fl_rd_addr != 21'h01ffff;
	endsequence
	sequence s_last;
		fl_rd_valid && !cfg_done && fl_rd_addr == 21'h01ffff;
	endsequence

	property p_vec_addr;
		vec_req |=> vec_ans.valid && vec_ans.fetch_addr == {$past(vector_base), 7'h00} + 21'($past(vec_num)) * 21'h2;
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("vector fetch address wrong");
	property p_reset_slot;
		vec_req |=> vec_ans.reset_slot == ($past(vector_base) == 14'h0200 && $past(vec_num) < 2);
	endproperty
	a_reset_slot: assert property (p_reset_slot) else $error("reset slot flag wrong");
	property p_evt;
		|evt_pending |=> evt_req && evt_vec >= 7'h4a && evt_vec <= 7'h50 && evt_level <= 2'h2;
	endproperty
	a_evt: assert property (p_evt) else $error("event vector out of range");
	property p_debug;
		data_req && data_addr >= 24'hffff00 |=> data_dec.region == MMD_RGN_DEBUG;
	endproperty
	a_debug: assert property (p_debug) else $error("debug window not decoded");
	property p_periph;
		data_req && data_addr[23:12] == 12'h00f |=> data_dec.region == MMD_RGN_PERIPH;
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral window not decoded");
	property p_low_ext;
		data_req && sel_w && data_addr < 24'h003000 |=> data_dec.region == MMD_RGN_EXTERNAL;
	endproperty
	a_low_ext: assert property (p_low_ext) else $error("low region not external");
	property p_ram;
		data_req && !sel_w && data_addr < 24'h002000 |=> data_dec.region == MMD_RGN_RAM && data_dec.ram_row == $past(row_w);
	endproperty
	a_ram: assert property (p_ram) else $error("RAM decode wrong");
	property p_dflash;
		data_req && !sel_w && data_addr[23:12] == 12'h002 |=> data_dec.region == MMD_RGN_DFLASH;
	endproperty
	a_dflash: assert property (p_dflash) else $error("data flash decode wrong");
	property p_cfg_next;
		s_more |=> fl_rd_req && fl_rd_addr == $past(fl_rd_addr) + 21'h1;
	endproperty
	a_cfg_next: assert property (p_cfg_next) else $error("next config read missing");
	property p_cfg_done;
		s_last |=> cfg_done && !fl_rd_req;
	endproperty
	a_cfg_done: assert property (p_cfg_done) else $error("config load not finished");
endmodule : mmd_checker

bind mmd_memory_map_decoder mmd_checker #(.VEC_W(VEC_W)) u_mmd_checker (.core_clk, .rst, .vec_req,
	.vector_base, .vec_num, .vec_ans, .evt_pending, .evt_req, .evt_vec, .evt_level, .data_req, .data_addr,
	.external_data_select, .data_dec, .fl_rd_req, .fl_rd_addr, .fl_rd_valid, .cfg_done);

// ==== testbench/mmd_flash_model.sv ====
// Program flash read port as seen by the decoder during the configuration load.
// Assumes one read outstanding at a time; odd addresses answer slowly.
module mmd_flash_model (
	input wire logic         core_clk,
	input wire logic         rst,
	input wire logic         fl_rd_req,
	input wire logic [20:0]  fl_rd_addr,
	output logic             fl_rd_valid,
	output logic [15:0]      fl_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       wait_q;
	logic [2:0] cnt_q;

	// Data toggles when idle so a stale word is never mistaken for a fresh one.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b0;
			cnt_q <= 3'h0;
			fl_rd_valid <= 1'b0;
			fl_rd_data <= 16'h0000;
		end else begin
			fl_rd_valid <= 1'b0;
			fl_rd_data <= ~fl_rd_data;
			if (fl_rd_req) begin
				wait_q <= 1'b1;
				cnt_q <= fl_rd_addr[0] ? 3'h3 : 3'h0;
			end else if (wait_q && cnt_q == 3'h0) begin
				wait_q <= 1'b0;
				fl_rd_valid <= 1'b1;
				fl_rd_data <= {12'hc30, fl_rd_addr[3:0]};
			end else if (wait_q) begin
				cnt_q <= cnt_q - 3'h1;
			end
		end
	end
endmodule : mmd_flash_model

// ==== testbench/memory_map_decoder_test.sv ====
// Self-checking bench for the memory map decoder.
// Assumes the flash model on the read port and the bound checker.
module memory_map_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	import mmd_pkg::*;

	logic core_clk = 0, rst = 1, vec_req = 0, data_req = 0, data_long = 0, external_data_select = 0, geom_req = 0;
	logic [13:0] vector_base = 0, evt_prio = 0;
	logic [6:0] vec_num = 0, evt_pending = 0, evt_vec;
	logic [15:0] vec_word_lo = 16'h5a3c, vec_word_hi = 16'hfffd, fl_rd_data;
	logic [23:0] data_addr = 0;
	logic [16:0] geom_off = 0;
	mmd_block_t geom_block = MMD_BLK_PROGRAM;
	mmd_vec_ans_t vec_ans;
	mmd_data_dec_t data_dec;
	mmd_geom_t geom;
	logic evt_req, fl_rd_req, fl_rd_valid, cfg_done;
	logic [1:0] evt_level;
	logic [20:0] fl_rd_addr;
	logic [143:0] flash_cfg;
	int failures = 0, total_checks = 0, cycles = 0;

	mmd_memory_map_decoder DUT (.core_clk, .rst, .vec_req, .vector_base, .vec_num, .vec_word_lo, .vec_word_hi,
		.vec_ans, .evt_pending, .evt_prio, .evt_req, .evt_vec, .evt_level, .data_req, .data_addr, .data_long,
		.external_data_select, .data_dec, .geom_req, .geom_block, .geom_off, .geom, .fl_rd_req, .fl_rd_addr,
		.fl_rd_valid, .fl_rd_data, .flash_cfg, .cfg_done);
	mmd_flash_model u_flash (.core_clk, .rst, .fl_rd_req, .fl_rd_addr, .fl_rd_valid, .fl_rd_data);

	// ----------------------------------------
	// Clock, watchdog and shared tasks
	// ----------------------------------------
	always #5 core_clk = ~core_clk;

	// The whole run needs well under a thousand cycles; a hang is cut off here.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			finish_test();
		end
	end

	task chk(logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task finish_test;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	// Waits for the nine words and checks each against the model pattern.
	task t_cfg;
		for (int i = 0; i < 400 && !cfg_done; i++) @(negedge core_clk);
		chk(cfg_done, 1);
		chk(fl_rd_req, 0);
		for (int i = 0; i < 9; i++) chk(flash_cfg[16*i +: 16], {12'hc30, 4'(7 + i)});
	endtask : t_cfg

	task t_vec(logic [13:0] b, logic [6:0] n);
		logic rs;
		rs = b == 14'h0200 && n < 2;
		vec_req = 1;
		vector_base = b;
		vec_num = n;
		@(negedge core_clk);
		chk(vec_ans.valid, 1);
		chk(vec_ans.fetch_addr, {b, 7'h00} + {13'h0, n, 1'b0});
		chk(vec_ans.reset_slot, rs);
		chk(vec_ans.jump_target, rs ? 21'h0 : 21'h055a3c);
	endtask : t_vec

	// Back-to-back decodes at the region boundaries, addresses 0 and 2fff in both select settings, the others in one.
	task t_data;
		logic [23:0] ad[14] = '{24'h0, 24'h1fff, 24'h2000, 24'h2fff, 24'h3000, 24'h0, 24'h2fff, 24'hf000,
			24'hffff, 24'h10000, 24'hfffeff, 24'hffff00, 24'hffffff, 24'h0a46};
		logic [0:13] sl = 14'b00000111001100;
		mmd_region_t rg[14] = '{MMD_RGN_RAM, MMD_RGN_RAM, MMD_RGN_DFLASH, MMD_RGN_DFLASH, MMD_RGN_EXTERNAL,
			MMD_RGN_EXTERNAL, MMD_RGN_EXTERNAL, MMD_RGN_PERIPH, MMD_RGN_PERIPH, MMD_RGN_EXTERNAL,
			MMD_RGN_EXTERNAL, MMD_RGN_DEBUG, MMD_RGN_DEBUG, MMD_RGN_RAM};
		data_req = 1;
		data_long = 1;
		for (int i = 0; i < 14; i++) begin
			data_addr = ad[i];
			external_data_select = sl[i];
			@(negedge core_clk);
			chk(data_dec.region, rg[i]);
		end
		chk({data_dec.ram_row, data_dec.ram_upper, data_dec.long_ok}, {11'h523, 2'b01});
		data_addr = 24'h0a47;
		@(negedge core_clk);
		data_req = 0;
		chk({data_dec.ram_upper, data_dec.long_ok}, 2'b10);
		@(negedge core_clk);
		chk(data_dec.valid, 0);
	endtask : t_data

	// Ties go to the lower vector; a priority of three counts as two.
	task t_evt;
		evt_pending = 7'h7f;
		evt_prio = 14'h3003;
		@(negedge core_clk);
		chk({evt_vec, evt_level}, {7'h4a, 2'h2});
		evt_prio = 14'h0c01;
		@(negedge core_clk);
		chk({evt_vec, evt_level}, {7'h4f, 2'h2});
		evt_pending = 0;
		@(negedge core_clk);
		chk(evt_req, 0);
	endtask : t_evt

	task t_geom(mmd_block_t b, logic [16:0] o, logic [8:0] exp);
		geom_req = 1;
		geom_block = b;
		geom_off = o;
		@(negedge core_clk);
		chk(geom.valid, 1);
		chk({geom.sector, geom.page, geom.data_bank}, exp);
	endtask : t_geom

	initial begin
		repeat (2) @(negedge core_clk);
		rst = 0;
		t_cfg();
		t_vec(14'h0200, 7'd0);
		t_vec(14'h0200, 7'd1);
		t_vec(14'h0200, 7'd74);
		t_vec(14'h0000, 7'd1);
		t_vec(14'h0123, 7'd80);
		vec_req = 0;
		t_data();
		t_evt();
		t_geom(MMD_BLK_PROGRAM, 17'h15a00, 9'h15a);
		t_geom(MMD_BLK_DATA, 17'h00a00, 9'h141);
		t_geom(MMD_BLK_BOOT, 17'h01d00, 9'h06a);
		geom_req = 0;
		@(negedge core_clk);
		chk(geom.valid, 0);
		chk(vec_ans.valid, 0);
		rst = 1;
		@(negedge core_clk);
		rst = 0;
		t_cfg();
		finish_test();
	end
endmodule : memory_map_decoder_test
